// *** hdl/rio_params.svh ***
`ifndef RIO_PARAMS_SVH
`define RIO_PARAMS_SVH

// connections supervised
`define RIO_NCONN 3

// error-status codes
`define RIO_CODE_NORMAL 8'h00
`define RIO_CODE_TIMEOUT 8'h01
`define RIO_CODE_DISC 8'h02
`define RIO_CODE_SLVERR 8'h0A

// timing: core clock and the 100 ms timeout step
`define RIO_CLK_HZ 200000000
`define RIO_TICK_MS 100
`define RIO_TICK_CYCLES ((`RIO_CLK_HZ / 1000) * `RIO_TICK_MS)

// reset values and the smallest timeout
`define RIO_CTRL_RST 3'h7
`define RIO_TMO_RST 8'h14
`define RIO_TMO_MIN 8'h01
`define RIO_PORT_RST 16'h083E

// register byte offsets
`define RIO_A_CTRL 8'h00
`define RIO_A_STAT 8'h04
`define RIO_A_CODE 8'h08
`define RIO_A_IRQ_STAT 8'h0C
`define RIO_A_IRQ_MASK 8'h10
`define RIO_A_TMO0 8'h14
`define RIO_A_PORT0 8'h20
`define RIO_A_TOCNT 8'h2C

// status register field positions
`define RIO_STAT_ERR_LSB 0
`define RIO_STAT_CONN_LSB 4
`define RIO_STAT_OUTS_LSB 8

`endif

// *** hdl/rio_pkg.sv ***
package rio_pkg;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h1,
		ST_OPEN = 3'h2,
		ST_LINK = 3'h4
	} rio_conn_state_type;

endpackage

// *** hdl/rio_tick.sv ***
`include "rio_params.svh"

module rio_tick #(
	parameter int TICK_CYCLES = `RIO_TICK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// 100 ms step pulse
	output logic tick
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic tick_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r + 32'h00000001;
		tick_nxt = 1'b0;
		if (cnt_r >= 32'(TICK_CYCLES - 1))
		begin
			cnt_nxt = 32'h00000000;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cnt_r <= 32'h00000000;
			tick <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick <= tick_nxt;
		end
	end

endmodule

// *** hdl/rio_conn.sv ***
`include "rio_params.svh"

module rio_conn (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pacing and configuration
	input wire logic enable,
	input wire logic scan_end,
	input wire logic tick,
	input wire logic [7:0] timeout_units,
	// network engine events
	input wire logic conn_ok,
	input wire logic conn_fail,
	input wire logic link_drop,
	input wire logic resp_valid,
	input wire logic resp_err,
	// requests to the engine
	output logic open_req,
	output logic data_req,
	// state
	output logic err_flag,
	output logic [7:0] code,
	output logic connected,
	output logic outstanding,
	// one-cycle events
	output logic err_rise,
	output logic err_fall,
	output logic timeout_evt
);

	rio_pkg::rio_conn_state_type state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt, code_nxt, limit;
	logic err_nxt, conn_nxt, outs_nxt, open_nxt, data_nxt, to_nxt;

	assign limit = (timeout_units < `RIO_TMO_MIN) ? `RIO_TMO_MIN : timeout_units;

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		code_nxt = code;
		err_nxt = err_flag;
		conn_nxt = connected;
		outs_nxt = outstanding;
		open_nxt = 1'b0;
		data_nxt = 1'b0;
		to_nxt = 1'b0;
		case (state_r)
			rio_pkg::ST_IDLE:
			begin
				// retry the open only at end of scan
				if (scan_end && enable)
				begin
					open_nxt = 1'b1;
					state_nxt = rio_pkg::ST_OPEN;
				end
			end
			rio_pkg::ST_OPEN:
			begin
				if (conn_ok)
				begin
					state_nxt = rio_pkg::ST_LINK;
					code_nxt = `RIO_CODE_NORMAL;
					err_nxt = 1'b0;
					conn_nxt = 1'b1;
				end
				else if (conn_fail)
				begin
					// flag and code 2 stay as they are
					state_nxt = rio_pkg::ST_IDLE;
				end
			end
			rio_pkg::ST_LINK:
			begin
				if (link_drop || !enable)
				begin
					state_nxt = rio_pkg::ST_IDLE;
					code_nxt = `RIO_CODE_DISC;
					err_nxt = 1'b1;
					conn_nxt = 1'b0;
					outs_nxt = 1'b0;
				end
				else if (outstanding)
				begin
					if (resp_valid)
					begin
						outs_nxt = 1'b0;
						// late answer also lands here and restores normal, or sets code 10 on an error answer
						code_nxt = resp_err ? `RIO_CODE_SLVERR : `RIO_CODE_NORMAL;
						err_nxt = resp_err;
					end
					else if (tick && cnt_r != 8'hFF)
					begin
						cnt_nxt = cnt_r + 8'h01;
						if (cnt_nxt == limit)
						begin
							code_nxt = `RIO_CODE_TIMEOUT;
							err_nxt = 1'b1;
							to_nxt = 1'b1;
						end
					end
				end
				else if (scan_end)
				begin
					data_nxt = 1'b1;
					outs_nxt = 1'b1;
					cnt_nxt = 8'h00;
				end
			end
			default:
			begin
				state_nxt = rio_pkg::ST_IDLE;
			end
		endcase
	end

	assign err_rise = err_nxt & ~err_flag;
	assign err_fall = ~err_nxt & err_flag;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_r <= rio_pkg::ST_IDLE;
			cnt_r <= 8'h00;
			code <= `RIO_CODE_DISC;
			err_flag <= 1'b1;
			connected <= 1'b0;
			outstanding <= 1'b0;
			open_req <= 1'b0;
			data_req <= 1'b0;
			timeout_evt <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			code <= code_nxt;
			err_flag <= err_nxt;
			connected <= conn_nxt;
			outstanding <= outs_nxt;
			open_req <= open_nxt;
			data_req <= data_nxt;
			timeout_evt <= to_nxt;
		end
	end

endmodule

// *** hdl/rio_sup.sv ***
// Chosen here: the address-and-strobe port and the register addresses.
`include "rio_params.svh"

module rio_sup #(
	parameter int TICK_CYCLES = `RIO_TICK_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// interrupt
	output logic irq,
	// scan pacing
	input wire logic scan_end,
	// network engine, one bit or one 16-bit target port per connection
	input wire logic [2:0] conn_ok,
	input wire logic [2:0] conn_fail,
	input wire logic [2:0] link_drop,
	input wire logic [2:0] resp_valid,
	input wire logic [2:0] resp_err,
	output logic [2:0] open_req,
	output logic [2:0] data_req,
	output logic [15:0] slave1_port,
	output logic [15:0] slave2_port,
	output logic [15:0] slave3_port,
	// per-connection status
	output logic slave1_comm_error_flag,
	output logic slave2_comm_error_flag,
	output logic slave3_comm_error_flag,
	output logic [7:0] slave1_error_status_code,
	output logic [7:0] slave2_error_status_code,
	output logic [7:0] slave3_error_status_code,
	output logic slave1_connected_flag,
	output logic slave2_connected_flag,
	output logic slave3_connected_flag
);

	localparam int NC = `RIO_NCONN;

	logic tick;
	logic [2:0] err_flag, connected, outstanding, err_rise, err_fall, timeout_evt;
	logic [7:0] code [NC];

	// software state
	logic [2:0] ctrl_r, ctrl_nxt;
	logic [5:0] irq_r, irq_nxt, mask_r, mask_nxt;
	logic [7:0] tmo_r [NC];
	logic [7:0] tmo_nxt [NC];
	logic [15:0] port_r [NC];
	logic [15:0] port_nxt [NC];
	logic [7:0] tocnt_r [NC];
	logic [7:0] tocnt_nxt [NC];
	logic [31:0] rdata_nxt;

	// index of a per-connection word, 3 when outside the block
	function automatic logic [1:0] slot(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		if (a < base || d[1:0] != 2'b00 || d[7:2] >= 6'(NC))
			slot = 2'h3;
		else
			slot = d[3:2];
	endfunction

	// three per-connection bytes in one read word, connection 1 lowest
	function automatic logic [31:0] pack3(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] b2);
		pack3 = {8'h00, b2, b1, b0};
	endfunction

	rio_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.tick(tick)
	);

	// one independent supervisor per connection, all fed the same scan end
	for (genvar i = 0; i < NC; i++)
	begin : g_conn
		rio_conn u_conn (
			.core_clk(core_clk),
			.rst(rst),
			.enable(ctrl_r[i]),
			.scan_end(scan_end),
			.tick(tick),
			.timeout_units(tmo_r[i]),
			.conn_ok(conn_ok[i]),
			.conn_fail(conn_fail[i]),
			.link_drop(link_drop[i]),
			.resp_valid(resp_valid[i]),
			.resp_err(resp_err[i]),
			.open_req(open_req[i]),
			.data_req(data_req[i]),
			.err_flag(err_flag[i]),
			.code(code[i]),
			.connected(connected[i]),
			.outstanding(outstanding[i]),
			.err_rise(err_rise[i]),
			.err_fall(err_fall[i]),
			.timeout_evt(timeout_evt[i])
		);
	end

	assign slave1_comm_error_flag = err_flag[0];
	assign slave2_comm_error_flag = err_flag[1];
	assign slave3_comm_error_flag = err_flag[2];
	assign slave1_error_status_code = code[0];
	assign slave2_error_status_code = code[1];
	assign slave3_error_status_code = code[2];
	assign slave1_connected_flag = connected[0];
	assign slave2_connected_flag = connected[1];
	assign slave3_connected_flag = connected[2];
	assign slave1_port = port_r[0];
	assign slave2_port = port_r[1];
	assign slave3_port = port_r[2];

	assign irq = |(irq_r & mask_r);

	// control, mask and interrupt status
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		irq_nxt = irq_r;
		if (reg_wr)
		begin
			case (reg_addr)
				`RIO_A_CTRL:
				begin
					// a cleared enable drops that link to code 2
					ctrl_nxt = reg_wdata[2:0];
				end
				`RIO_A_IRQ_MASK:
				begin
					mask_nxt = reg_wdata[5:0];
				end
				`RIO_A_IRQ_STAT:
				begin
					irq_nxt = irq_r & ~reg_wdata[5:0];
				end
				default:
				begin
					ctrl_nxt = ctrl_r;
				end
			endcase
		end
		// a new event wins over a same-cycle clear
		irq_nxt = irq_nxt | {err_fall, err_rise};
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl_r <= `RIO_CTRL_RST;
			mask_r <= 6'h00;
			irq_r <= 6'h00;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// per-connection timeout, target port and timeout count
	always_comb
	begin
		logic [1:0] ts;
		logic [1:0] ps;
		ts = slot(reg_addr, `RIO_A_TMO0);
		ps = slot(reg_addr, `RIO_A_PORT0);
		for (int i = 0; i < NC; i++)
		begin
			tmo_nxt[i] = tmo_r[i];
			port_nxt[i] = port_r[i];
			tocnt_nxt[i] = tocnt_r[i];
			if (reg_wr && ts == 2'(i))
			begin
				tmo_nxt[i] = reg_wdata[7:0];
			end
			if (reg_wr && ps == 2'(i))
			begin
				port_nxt[i] = reg_wdata[15:0];
			end
			// any write to the count register clears, a timeout in the same cycle still counts
			if (reg_wr && reg_addr == `RIO_A_TOCNT)
			begin
				tocnt_nxt[i] = 8'h00;
			end
			if (timeout_evt[i] && tocnt_nxt[i] != 8'hFF)
			begin
				tocnt_nxt[i] = tocnt_nxt[i] + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < NC; i++)
			begin
				tmo_r[i] <= `RIO_TMO_RST;
				port_r[i] <= `RIO_PORT_RST;
				tocnt_r[i] <= 8'h00;
			end
		end
		else
		begin
			for (int i = 0; i < NC; i++)
			begin
				tmo_r[i] <= tmo_nxt[i];
				port_r[i] <= port_nxt[i];
				tocnt_r[i] <= tocnt_nxt[i];
			end
		end
	end

	// read data, valid only in the cycle after the strobe
	always_comb
	begin
		logic [1:0] ts;
		logic [1:0] ps;
		ts = slot(reg_addr, `RIO_A_TMO0);
		ps = slot(reg_addr, `RIO_A_PORT0);
		rdata_nxt = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				`RIO_A_CTRL:
				begin
					rdata_nxt[2:0] = ctrl_r;
				end
				`RIO_A_STAT:
				begin
					rdata_nxt[`RIO_STAT_ERR_LSB +: 3] = err_flag;
					rdata_nxt[`RIO_STAT_CONN_LSB +: 3] = connected;
					rdata_nxt[`RIO_STAT_OUTS_LSB +: 3] = outstanding;
				end
				`RIO_A_CODE:
				begin
					rdata_nxt = pack3(code[0], code[1], code[2]);
				end
				`RIO_A_IRQ_STAT:
				begin
					rdata_nxt[5:0] = irq_r;
				end
				`RIO_A_IRQ_MASK:
				begin
					rdata_nxt[5:0] = mask_r;
				end
				`RIO_A_TOCNT:
				begin
					rdata_nxt = pack3(tocnt_r[0], tocnt_r[1], tocnt_r[2]);
				end
				default:
				begin
					// unmapped and misaligned addresses read as zero
					if (ts != 2'h3)
					begin
						rdata_nxt[7:0] = tmo_r[ts];
					end
					else if (ps != 2'h3)
					begin
						rdata_nxt[15:0] = port_r[ps];
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			reg_rdata <= 32'h00000000;
		end
		else
		begin
			reg_rdata <= rdata_nxt;
		end
	end

endmodule

// *** sim/rio_sup_checker.sv ***
module rio_sup_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// link side
	input wire logic scan_end,
	input wire logic [2:0] resp_valid,
	input wire logic [2:0] resp_err,
	input wire logic [2:0] open_req,
	input wire logic [2:0] data_req,
	// status
	input wire logic slave1_comm_error_flag,
	input wire logic slave2_comm_error_flag,
	input wire logic [7:0] slave1_error_status_code,
	input wire logic [7:0] slave2_error_status_code,
	input wire logic [7:0] slave3_error_status_code,
	input wire logic slave1_connected_flag,
	input wire logic slave2_connected_flag,
	input wire logic slave3_connected_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [2:0] outs_r;
	logic [2:0] outs_nxt;
	// requests still waiting for an answer
	always_comb outs_nxt = (outs_r | data_req) & ~resp_valid;
	always_ff @(posedge core_clk) outs_r <= rst ? 3'h0 : outs_nxt;
	sequence s_err_resp;
		resp_valid[2] && resp_err[2] && slave3_connected_flag;
	endsequence
	sequence s_ok_resp;
		resp_valid[1] && !resp_err[1] && slave2_connected_flag;
	endsequence
	a_data_at_scan: assert property (data_req != 3'h0 |-> $past(scan_end))
		else $error("data request outside scan end");
	a_open_at_scan: assert property (open_req != 3'h0 |-> $past(scan_end))
		else $error("open request outside scan end");
	a_one_outstanding: assert property ((data_req & outs_r) == 3'h0)
		else $error("second request while one is outstanding");
	a_code_legal: assert property (slave1_error_status_code inside {8'h00, 8'h01, 8'h02, 8'h0A})
		else $error("illegal status code");
	a_flag_code: assert property (slave2_comm_error_flag == (slave2_error_status_code != 8'h00))
		else $error("error flag disagrees with code");
	a_disc_code: assert property (!slave1_connected_flag |-> slave1_error_status_code == 8'h02 && slave1_comm_error_flag)
		else $error("unconnected but code not 2");
	a_conn_clears: assert property ($rose(slave1_connected_flag) |-> slave1_error_status_code == 8'h00 && !slave1_comm_error_flag)
		else $error("connect did not clear error");
	a_slave_err: assert property (s_err_resp |=> slave3_error_status_code == 8'h0A)
		else $error("slave error answer not code 10");
	a_late_answer: assert property (s_ok_resp |=> slave2_error_status_code == 8'h00)
		else $error("answer did not restore code 0");
	a_reset_state: assert property (disable iff (1'b0) rst |=> slave1_comm_error_flag && slave1_error_status_code == 8'h02)
		else $error("reset state wrong");
endmodule

// *** sim/rio_slave_model.sv ***
module rio_slave_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// requests from the master
	input wire logic [2:0] open_req,
	input wire logic [2:0] data_req,
	// behaviour chosen by the bench
	input wire logic [2:0] fail,
	input wire logic [2:0] hold,
	input wire logic [2:0] err,
	// answers
	output logic [2:0] conn_ok,
	output logic [2:0] conn_fail,
	output logic [2:0] resp_valid,
	output logic [2:0] resp_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] open_r, pend_r, go;
	assign go = pend_r & ~hold;
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			open_r <= 3'h0;
			pend_r <= 3'h0;
			conn_ok <= 3'h0;
			conn_fail <= 3'h0;
			resp_valid <= 3'h0;
			resp_err <= 3'h5;
		end
		else
		begin
			open_r <= open_req;
			conn_ok <= open_r & ~fail;
			conn_fail <= open_r & fail;
			// one answer per request, held back while told to stay silent
			pend_r <= (pend_r & hold) | data_req;
			resp_valid <= go;
			// qualifier toggles when no answer is on the lines
			resp_err <= (go & err) | (~go & ~resp_err);
		end
	end
endmodule

// *** sim/testbench.sv ***
`define CHK(n, e, v) chk(n, e, v)
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic scan_end = 1'b0;
	logic [2:0] fail = 3'h0, hold = 3'h0, err = 3'h0, drop = 3'h0;
	logic [31:0] reg_rdata;
	logic irq;
	logic [2:0] conn_ok, conn_fail, resp_valid, resp_err, open_req, data_req, flag, conn;
	logic [7:0] code [3];
	logic [15:0] port [3];
	int mismatches = 0;
	int n_checks = 0;
	initial forever #2.5 core_clk = ~core_clk;
	rio_sup #(.TICK_CYCLES(10)) DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .scan_end(scan_end), .conn_ok(conn_ok), .conn_fail(conn_fail),
		.link_drop(drop), .resp_valid(resp_valid), .resp_err(resp_err), .open_req(open_req),
		.data_req(data_req), .slave1_port(port[0]), .slave2_port(port[1]),
		.slave3_port(port[2]), .slave1_comm_error_flag(flag[0]),
		.slave2_comm_error_flag(flag[1]), .slave3_comm_error_flag(flag[2]),
		.slave1_error_status_code(code[0]), .slave2_error_status_code(code[1]),
		.slave3_error_status_code(code[2]), .slave1_connected_flag(conn[0]),
		.slave2_connected_flag(conn[1]), .slave3_connected_flag(conn[2]));
	rio_slave_model u_slave (.core_clk(core_clk), .rst(rst), .open_req(open_req),
		.data_req(data_req), .fail(fail), .hold(hold), .err(err), .conn_ok(conn_ok),
		.conn_fail(conn_fail), .resp_valid(resp_valid), .resp_err(resp_err));
	task automatic chk(string n, logic [31:0] e, logic [31:0] v);
		n_checks++;
		if (v !== e)
		begin
			$display("Error %s expected %h seen %h", n, e, v);
			mismatches++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, string n);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(n, e, reg_rdata);
	endtask
	// one scan end pulse, requests checked in the cycle they stand
	task automatic scan(logic [2:0] eo, logic [2:0] ed);
		@(posedge core_clk);
		scan_end <= 1'b1;
		@(posedge core_clk);
		scan_end <= 1'b0;
		#1;
		`CHK("open_req", eo, open_req);
		`CHK("data_req", ed, data_req);
	endtask
	task automatic wcode(int n, logic [7:0] v);
		int i;
		for (i = 0; i < 100 && code[n] !== v; i++)
		begin
			@(posedge core_clk);
			#1;
		end
		`CHK("code", v, code[n]);
		if (code[n] !== v)
			report_and_stop();
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		`CHK("flags", 3'h7, flag);
		`CHK("connected", 3'h0, conn);
		for (int i = 0; i < 3; i++)
		begin
			`CHK("code", 8'h02, code[i]);
			`CHK("port", 16'h083E, port[i]);
		end
		rd(8'h08, 32'h00020202, "code reg");
		rd(8'h04, 32'h00000007, "status reg");
		rd(8'h40, 32'h0, "unmapped");
		rd(8'h10, 32'h0, "irq mask");
		rd(8'h18, 32'h14, "timeout2");
		wr(8'h18, 32'h2);
		rd(8'h18, 32'h2, "timeout2");
		wr(8'h10, 32'h38);
		fail <= 3'h1;
		scan(3'h7, 3'h0);
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("flag1", 1'b1, flag[0]);
		`CHK("code1", 8'h02, code[0]);
		wcode(1, 8'h00);
		`CHK("connected", 3'h6, conn);
		fail <= 3'h0;
		scan(3'h1, 3'h6);
		wcode(0, 8'h00);
		`CHK("connected", 3'h7, conn);
		`CHK("irq", 1'b1, irq);
		wr(8'h0C, 32'h38);
		#1;
		`CHK("irq", 1'b0, irq);
		hold <= 3'h2;
		err <= 3'h4;
		scan(3'h0, 3'h7);
		repeat (3) @(posedge core_clk);
		scan(3'h0, 3'h5);
		wcode(2, 8'h0A);
		`CHK("flag3", 1'b1, flag[2]);
		wcode(1, 8'h01);
		`CHK("flag2", 1'b1, flag[1]);
		rd(8'h2C, 32'h00000100, "timeout count");
		hold <= 3'h0;
		wcode(1, 8'h00);
		`CHK("flag2", 1'b0, flag[1]);
		@(posedge core_clk);
		drop <= 3'h4;
		@(posedge core_clk);
		drop <= 3'h0;
		wcode(2, 8'h02);
		`CHK("flag3", 1'b1, flag[2]);
		`CHK("connected", 3'h3, conn);
		scan(3'h4, 3'h3);
		wcode(2, 8'h00);
		`CHK("irq", 1'b1, irq);
		rd(8'h0C, 32'h00000036, "irq status");
		report_and_stop();
	end
endmodule
bind rio_sup rio_sup_checker u_chk (.core_clk(core_clk), .rst(rst), .scan_end(scan_end),
	.resp_valid(resp_valid), .resp_err(resp_err), .open_req(open_req), .data_req(data_req),
	.slave1_comm_error_flag(slave1_comm_error_flag),
	.slave2_comm_error_flag(slave2_comm_error_flag),
	.slave1_error_status_code(slave1_error_status_code),
	.slave2_error_status_code(slave2_error_status_code),
	.slave3_error_status_code(slave3_error_status_code),
	.slave1_connected_flag(slave1_connected_flag),
	.slave2_connected_flag(slave2_connected_flag),
	.slave3_connected_flag(slave3_connected_flag));
